// file: nstpf_pkg.sv
// nstpf_pkg.sv
// constants, register offsets and types for the status/time packet formatter
// assumes a 50 MHz system clock
package nstpf_pkg;
  // ==========================================================
  // clock and time
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned US_PER_S = 1_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / US_PER_S;
  localparam logic [19:0] US_MAX = 20'hF423F; // 999999
  localparam logic [5:0] US_CYC_LAST = 6'(CYC_PER_US - 1);
  // ==========================================================
  // filter status word fields
  localparam int FS_ORIENT_INIT = 0;
  localparam int FS_NAV_INIT = 1;
  localparam int FS_HEAD_INIT = 2;
  localparam int FS_UTC_INIT = 3;
  localparam int FS_FIX_LSB = 4;
  localparam int FS_EVENT1 = 7;
  localparam int FS_EVENT2 = 8;
  localparam int FS_FLAGS_LSB = 9;
  localparam logic [15:0] FS_RESET = 16'h0000;
  // ==========================================================
  // fix type codes
  typedef enum logic [2:0] {
    FIX_NONE = 3'h0, FIX_2D = 3'h1, FIX_3D = 3'h2, FIX_AUG = 3'h3,
    FIX_DIFF = 3'h4, FIX_PPP = 3'h5, FIX_CFLOAT = 3'h6, FIX_CFIXED = 3'h7
  } nstpf_fix_type;
  // ==========================================================
  // packet identifiers and payload lengths
  localparam logic [7:0] PID_UNIX = 8'h15;
  localparam logic [7:0] PID_CAL = 8'h16;
  localparam logic [7:0] PID_STAT = 8'h17;
  localparam logic [7:0] PID_POSDEV = 8'h18;
  localparam logic [7:0] PID_VELDEV = 8'h19;
  localparam logic [7:0] PID_EULDEV = 8'h1A;
  localparam logic [7:0] PID_QDEV = 8'h1B;
  localparam logic [4:0] LEN_UNIX = 5'h08;
  localparam logic [4:0] LEN_CAL = 5'h0E;
  localparam logic [4:0] LEN_STAT = 5'h04;
  localparam logic [4:0] LEN_DEV3 = 5'h0C;
  localparam logic [4:0] LEN_QDEV = 5'h10;
  localparam int PAY_MAX = 16;
  // ==========================================================
  // register byte offsets
  localparam logic [5:0] R_SEC = 6'h00;     // rw seconds
  localparam logic [5:0] R_USEC = 6'h04;    // rw microseconds
  localparam logic [5:0] R_SYS = 6'h08;     // rw system status
  localparam logic [5:0] R_FLT = 6'h0C;     // rw filter flags, ro bits
  localparam logic [5:0] R_CAL0 = 6'h10;    // year, year day
  localparam logic [5:0] R_CAL1 = 6'h14;    // month, mday, wday, hour
  localparam logic [5:0] R_CAL2 = 6'h18;    // minute, second
  localparam logic [5:0] R_DEV = 6'h1C;     // deviation word write port
  localparam logic [5:0] R_SEND = 6'h20;    // wo packet id to send
  localparam logic [5:0] R_IRQ_ST = 6'h24;  // ro sticky status
  localparam logic [5:0] R_IRQ_CLR = 6'h28; // wo clear
  localparam logic [5:0] R_IRQ_EN = 6'h2C;  // rw enable
  localparam logic [5:0] R_BUSY = 6'h30;    // ro busy
  localparam int IRQ_DONE = 0;
  localparam int IRQ_EV1 = 1;
  localparam int IRQ_EV2 = 2;
  localparam int IRQ_ROLL = 3;
  localparam int IRQ_BAD = 4;
  // ==========================================================
  // serialiser states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01, ST_SEND = 2'b10
  } nstpf_state_type;
endpackage

// file: nstpf_time.sv
// nstpf_time.sv
// unix seconds and microseconds counter with software load
// assumes i_ce freezes the count and load inputs come from the same clock
`timescale 1ns/1ps
module nstpf_time
  import nstpf_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // loads
  input wire logic i_ld_sec,
  input wire logic i_ld_us,
  input wire logic [31:0] i_wdata,
  // time out
  output logic [31:0] o_sec,
  output logic [19:0] o_us,
  output logic o_roll
);
  logic [5:0] cyc_ff;
  logic [31:0] sec_ff;
  logic [19:0] us_ff;
  logic roll_ff;
  wire tick = (cyc_ff == US_CYC_LAST);
  wire us_wrap = tick && (us_ff == US_MAX);
  wire [19:0] ld_us_val = (i_wdata[19:0] > US_MAX) ? US_MAX : i_wdata[19:0];
  // ==========================================================
  // microsecond tick and time fields
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cyc_ff <= 6'h00;
      sec_ff <= 32'h0000_0000;
      us_ff <= 20'h00000;
      roll_ff <= 1'b0;
    end else if (i_ce) begin
      cyc_ff <= tick ? 6'h00 : cyc_ff + 6'h01;
      roll_ff <= us_wrap;
      if (i_ld_sec) begin
        sec_ff <= i_wdata;
      end else if (us_wrap) begin
        sec_ff <= sec_ff + 32'h0000_0001;
      end
      if (i_ld_us) begin
        us_ff <= ld_us_val;
      end else if (tick) begin
        us_ff <= us_wrap ? 20'h00000 : us_ff + 20'h00001;
      end
    end
  end
  assign o_sec = sec_ff;
  assign o_us = us_ff;
  assign o_roll = roll_ff;

  chk_us_range: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    us_ff <= US_MAX) else $error("microseconds out of range");
  chk_wrap_carry: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && us_wrap && !i_ld_sec && !i_ld_us) |=>
    (us_ff == 20'h00000 && sec_ff == $past(sec_ff) + 32'h0000_0001))
    else $error("second carry missing");
endmodule

// file: nstpf_ser.sv
// nstpf_ser.sv
// byte serialiser for a latched packet payload, lowest byte first
// assumes the consumer accepts a byte when o_valid and i_ready are high
`timescale 1ns/1ps
module nstpf_ser
  import nstpf_pkg::*;
#(
  parameter int MAXB = PAY_MAX
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // load
  input wire logic i_load,
  input wire logic [MAXB*8-1:0] i_payload,
  input wire logic [4:0] i_len,
  // byte stream
  output logic [7:0] o_data,
  output logic o_valid,
  output logic o_last,
  input wire logic i_ready,
  output logic o_done
);
  nstpf_state_type st_ff;
  logic [MAXB*8-1:0] buf_ff;
  logic [4:0] rem_ff;
  logic done_ff;
  wire fire = (st_ff == ST_SEND) && i_ready;
  // ==========================================================
  // shift out lowest byte first
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff <= ST_IDLE;
      buf_ff <= '0;
      rem_ff <= 5'h00;
      done_ff <= 1'b0;
    end else if (i_ce) begin
      done_ff <= 1'b0;
      unique case (st_ff)
        ST_IDLE: begin
          if (i_load) begin
            buf_ff <= i_payload;
            rem_ff <= i_len;
            st_ff <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (fire) begin
            buf_ff <= buf_ff >> 8;
            rem_ff <= rem_ff - 5'h01;
            if (rem_ff == 5'h01) begin
              st_ff <= ST_IDLE;
              done_ff <= 1'b1;
            end
          end
        end
      endcase
    end
  end
  assign o_data = buf_ff[7:0];
  assign o_valid = (st_ff == ST_SEND);
  assign o_last = (st_ff == ST_SEND) && (rem_ff == 5'h01);
  assign o_done = done_ff;
endmodule

// file: nstpf_top.sv
// nstpf_top.sv
// navigation status and time packet formatter with Avalon-MM registers
// assumes one 50 MHz clock; the sink takes bytes on valid and ready
//
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module nstpf_top
  import nstpf_pkg::*;
(
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // avalon-mm slave
  input wire logic [5:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // filter condition inputs, from same-clock logic
  input wire logic [3:0] i_init_flags,
  input wire logic [2:0] i_fix,
  input wire logic i_event1,
  input wire logic i_event2,
  // packet byte stream
  output logic [7:0] o_pkt_data,
  output logic o_pkt_valid,
  output logic o_pkt_last,
  output logic [7:0] o_pkt_id,
  output logic [4:0] o_pkt_len,
  input wire logic i_pkt_ready,
  // interrupt
  output logic o_irq
);
  // ==========================================================
  // bus access
  logic ack_ff;
  logic [31:0] rdata_ff;
  wire acc = (i_read || i_write) && !ack_ff;
  // a write lands on the edge where waitrequest is seen low
  wire wr = i_write && ack_ff && i_ce;
  wire [31:0] bmask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                       {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
  wire wr_sec = wr && (i_address == R_SEC);
  wire wr_us = wr && (i_address == R_USEC);
  wire wr_sys = wr && (i_address == R_SYS);
  wire wr_flt = wr && (i_address == R_FLT);
  wire wr_cal0 = wr && (i_address == R_CAL0);
  wire wr_cal1 = wr && (i_address == R_CAL1);
  wire wr_cal2 = wr && (i_address == R_CAL2);
  wire wr_dev = wr && (i_address == R_DEV);
  wire wr_send = wr && (i_address == R_SEND);
  wire wr_clr = wr && (i_address == R_IRQ_CLR);
  wire wr_en = wr && (i_address == R_IRQ_EN);
  assign o_waitrequest = (i_read || i_write) && !ack_ff;

  // ==========================================================
  // software-held state
  logic [15:0] sys_ff;
  logic [6:0] flt_ff;
  logic [31:0] cal0_ff, cal1_ff, cal2_ff;
  logic [31:0] dev_ff [0:15];
  logic [3:0] dptr_ff;
  logic [4:0] irq_st_ff, irq_en_ff;
  logic ev1_ff, ev2_ff, ev1_d_ff, ev2_d_ff;
  logic busy_ff;
  logic [7:0] id_ff;
  logic [4:0] len_ff;
  logic [31:0] sec;
  logic [19:0] us;
  logic roll, ser_done, ser_load;
  logic [127:0] pay;
  logic [4:0] plen;
  logic pid_ok;
  wire ev1_rise = i_event1 && !ev1_d_ff;
  wire ev2_rise = i_event2 && !ev2_d_ff;
  wire [15:0] flt_word;

  // filter status word from live conditions and software flags
  assign flt_word = {flt_ff, ev2_ff, ev1_ff, i_fix, i_init_flags};

  // ==========================================================
  // time counter
  nstpf_time u_time (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .i_ld_sec(wr_sec),
    .i_ld_us(wr_us),
    .i_wdata(i_writedata),
    .o_sec(sec),
    .o_us(us),
    .o_roll(roll)
  );

  // ==========================================================
  // payload selection by packet id
  always_comb begin
    pay = '0;
    plen = 5'h00;
    pid_ok = 1'b1;
    unique case (i_writedata[7:0])
      PID_UNIX: begin
        pay[63:0] = {12'h000, us, sec};
        plen = LEN_UNIX;
      end
      PID_CAL: begin
        pay[111:0] = {cal2_ff[15:0], cal1_ff, cal0_ff, 12'h000, us};
        plen = LEN_CAL;
      end
      PID_STAT: begin
        pay[31:0] = {flt_word, sys_ff};
        plen = LEN_STAT;
      end
      PID_POSDEV: begin
        pay[95:0] = {dev_ff[2], dev_ff[1], dev_ff[0]};
        plen = LEN_DEV3;
      end
      PID_VELDEV: begin
        pay[95:0] = {dev_ff[5], dev_ff[4], dev_ff[3]};
        plen = LEN_DEV3;
      end
      PID_EULDEV: begin
        pay[95:0] = {dev_ff[8], dev_ff[7], dev_ff[6]};
        plen = LEN_DEV3;
      end
      PID_QDEV: begin
        pay = {dev_ff[12], dev_ff[11], dev_ff[10], dev_ff[9]};
        plen = LEN_QDEV;
      end
      default: begin
        pid_ok = 1'b0;
      end
    endcase
  end
  assign ser_load = wr_send && pid_ok && !busy_ff;

  // ==========================================================
  // byte serialiser
  nstpf_ser #(.MAXB(PAY_MAX)) u_ser (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .i_load(ser_load),
    .i_payload(pay),
    .i_len(plen),
    .o_data(o_pkt_data),
    .o_valid(o_pkt_valid),
    .o_last(o_pkt_last),
    .i_ready(i_pkt_ready),
    .o_done(ser_done)
  );

  // ==========================================================
  // bus handshake and read data
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_ff <= 1'b0;
    end else if (i_ce) begin
      ack_ff <= acc;
    end
  end

  // registers written by software
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sys_ff <= 16'h0000;
      flt_ff <= 7'h00;
      cal0_ff <= 32'h0000_0000;
      cal1_ff <= 32'h0000_0000;
      cal2_ff <= 32'h0000_0000;
      dptr_ff <= 4'h0;
      irq_en_ff <= 5'h00;
    end else if (i_ce) begin
      if (wr_sys) sys_ff <= (sys_ff & ~bmask[15:0]) | (i_writedata[15:0] & bmask[15:0]);
      if (wr_flt) flt_ff <= i_writedata[15:9];
      if (wr_cal0) cal0_ff <= (cal0_ff & ~bmask) | (i_writedata & bmask);
      if (wr_cal1) cal1_ff <= (cal1_ff & ~bmask) | (i_writedata & bmask);
      if (wr_cal2) cal2_ff <= (cal2_ff & ~bmask) | (i_writedata & bmask);
      if (wr_en) irq_en_ff <= i_writedata[4:0];
      if (wr_dev) dptr_ff <= (dptr_ff == 4'hC) ? 4'h0 : dptr_ff + 4'h1;
      if (wr_send) dptr_ff <= 4'h0;
    end
  end

  // deviation words, stored as raw single-precision bit patterns
  always_ff @(posedge i_clk) begin
    if (i_ce && wr_dev) begin
      dev_ff[dptr_ff] <= i_writedata;
    end
  end

  // events, sticky interrupt status and transmit state
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ev1_ff <= 1'b0;
      ev2_ff <= 1'b0;
      ev1_d_ff <= 1'b0;
      ev2_d_ff <= 1'b0;
      irq_st_ff <= 5'h00;
      busy_ff <= 1'b0;
      id_ff <= 8'h00;
      len_ff <= 5'h00;
    end else if (i_ce) begin
      ev1_d_ff <= i_event1;
      ev2_d_ff <= i_event2;
      ev1_ff <= ev1_rise | (ev1_ff & ~(wr_flt & i_writedata[FS_EVENT1]));
      ev2_ff <= ev2_rise | (ev2_ff & ~(wr_flt & i_writedata[FS_EVENT2]));
      irq_st_ff <= {wr_send & !ser_load, roll, ev2_rise, ev1_rise, ser_done}
        | (irq_st_ff & ~({5{wr_clr}} & i_writedata[4:0]));
      if (ser_load) begin
        busy_ff <= 1'b1;
        id_ff <= i_writedata[7:0];
        len_ff <= plen;
      end else if (ser_done) begin
        busy_ff <= 1'b0;
      end
    end
  end

  // read multiplexer, registered on the access cycle
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (i_ce && acc && i_read) begin
      unique case (i_address)
        R_SEC: rdata_ff <= sec;
        R_USEC: rdata_ff <= {12'h000, us};
        R_SYS: rdata_ff <= {16'h0000, sys_ff};
        R_FLT: rdata_ff <= {16'h0000, flt_word};
        R_CAL0: rdata_ff <= cal0_ff;
        R_CAL1: rdata_ff <= cal1_ff;
        R_CAL2: rdata_ff <= cal2_ff;
        R_IRQ_ST: rdata_ff <= {27'h0000000, irq_st_ff};
        R_IRQ_EN: rdata_ff <= {27'h0000000, irq_en_ff};
        R_BUSY: rdata_ff <= {27'h0000000, 5'(busy_ff)};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end
  end
  assign o_readdata = rdata_ff;
  assign o_irq = |(irq_st_ff & irq_en_ff);
  assign o_pkt_id = id_ff;
  assign o_pkt_len = len_ff;

  // ==========================================================
  // checks
  chk_fix_field: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    flt_word[6:4] == i_fix) else $error("fix code misplaced");
  chk_init_bits: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    flt_word[3:0] == i_init_flags) else $error("init flags wrong");
  chk_event_flag: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && ev1_rise) |=> flt_word[FS_EVENT1])
    else $error("event 1 not flagged");
  chk_unix_len: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (ser_load && i_writedata[7:0] == PID_UNIX) |=> (len_ff == LEN_UNIX))
    else $error("unix length wrong");
  chk_cal_len: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (ser_load && i_writedata[7:0] == PID_CAL) |=> (len_ff == LEN_CAL))
    else $error("calendar length wrong");
  chk_stat_first: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (ser_load && i_writedata[7:0] == PID_STAT) |=>
    (o_pkt_data == $past(sys_ff[7:0]) && o_pkt_valid))
    else $error("status packet first byte");
  chk_pos_first: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (ser_load && i_writedata[7:0] == PID_POSDEV) |=>
    (o_pkt_data == $past(dev_ff[0][7:0])))
    else $error("position deviation first byte");
  chk_vel_len: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (ser_load && i_writedata[7:0] == PID_VELDEV) |=> (len_ff == LEN_DEV3))
    else $error("velocity length wrong");
  chk_eul_len: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (ser_load && i_writedata[7:0] == PID_EULDEV) |=> (len_ff == LEN_DEV3))
    else $error("euler length wrong");
  chk_quat_len: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (ser_load && i_writedata[7:0] == PID_QDEV) |=> (len_ff == LEN_QDEV))
    else $error("quaternion length wrong");
  chk_sys_read: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && acc && i_read && i_address == R_SYS) |=>
    (o_readdata[31:16] == 16'h0000))
    else $error("system status upper bits");
endmodule

// file: nstpf_sink.sv
// nstpf_sink.sv
// host-side byte sink for the packet stream, records every accepted byte
// assumes the same clock as the formatter; i_slow stalls every other cycle
`timescale 1ns/1ps
module nstpf_sink (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // byte stream
  input wire logic [7:0] i_data,
  input wire logic i_valid,
  input wire logic i_last,
  output logic o_ready,
  // pacing
  input wire logic i_slow
);
  // ==========================================================
  // capture
  logic [7:0] got[$];
  logic lst[$];
  logic ph_ff;
  // ready toggles when slow, so each byte after the first waits out a one-cycle stall
  assign o_ready = !i_slow || ph_ff;
  // record bytes on valid and ready
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ph_ff <= 1'b0;
    end else begin
      ph_ff <= !ph_ff;
      if (i_valid && o_ready) begin
        got.push_back(i_data);
        lst.push_back(i_last);
      end
    end
  end
endmodule

// file: nstpf_bench.sv
// nstpf_bench.sv
// self-checking bench: register access, status word, time, packets, irq
// assumes the sink model records the stream; one 50 MHz clock
`timescale 1ns/1ps
module nstpf_bench
  import nstpf_pkg::*;
;
  // ==========================================================
  // signals
  logic i_clk, i_arst_n, i_read, i_write, o_waitrequest, i_event1, i_event2;
  logic [5:0] i_address;
  logic [31:0] i_writedata, o_readdata, q, s, u;
  logic [3:0] i_init_flags;
  logic [2:0] i_fix;
  logic [7:0] o_pkt_data, o_pkt_id, exp_q[$];
  logic [4:0] o_pkt_len;
  logic o_pkt_valid, o_pkt_last, pready, o_irq, slow;
  int n_errors, cmp_count;
  // ==========================================================
  // design and host model
  nstpf_top u_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(1'b1),
    .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .i_byteenable(4'hF),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_init_flags(i_init_flags), .i_fix(i_fix), .i_event1(i_event1),
    .i_event2(i_event2), .o_pkt_data(o_pkt_data), .o_pkt_valid(o_pkt_valid),
    .o_pkt_last(o_pkt_last), .o_pkt_id(o_pkt_id), .o_pkt_len(o_pkt_len),
    .i_pkt_ready(pready), .o_irq(o_irq));
  nstpf_sink u_sink (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_data(o_pkt_data),
    .i_valid(o_pkt_valid), .i_last(o_pkt_last), .o_ready(pready),
    .i_slow(slow));
  // ==========================================================
  // compare and report
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (e !== g) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input logic [31:0] lo, hi, g);
    cmp_count++;
    if ($isunknown(g) || !(g >= lo && g <= hi)) begin
      n_errors++;
      $display("MISMATCH %s expected %h..%h seen %h", nm, lo, hi, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================================
  // avalon-mm master: hold until waitrequest is low at a rising edge
  task automatic bus(input logic w, input logic [5:0] a,
      input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= d;
    i_write <= w;
    i_read <= !w;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 50);
    @(posedge i_clk);
    r = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
    if (n >= 50) chk("bus_timeout", 0, 1);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask
  task automatic push(input logic [31:0] v, input int nb);
    for (int i = 0; i < nb; i++) exp_q.push_back(v[8*i+:8]);
  endtask
  // send a packet and compare the captured bytes; a live microsecond
  // field at byte uo is checked against its sampled lower bound ul
  task automatic pkt(input logic [7:0] id, input int len, uo,
      input logic [31:0] ul);
    int n;
    logic [31:0] g;
    u_sink.got.delete();
    u_sink.lst.delete();
    wr(R_SEND, {24'h0, id});
    @(negedge i_clk);
    chk("pkt_id", id, o_pkt_id);
    chk("pkt_len", len, o_pkt_len);
    n = 0;
    while (u_sink.got.size() < len && n < 500) begin
      @(posedge i_clk);
      n++;
    end
    repeat (4) @(posedge i_clk);
    chk("pkt_count", len, u_sink.got.size());
    for (int i = 0; i < len && i < u_sink.got.size(); i++) begin
      g = {u_sink.got[i+3], u_sink.got[i+2], u_sink.got[i+1], u_sink.got[i]};
      if (i == uo) chk_rng("pkt_usec", ul, ul + 2, g);
      else if (uo < 0 || i < uo || i > uo + 3) chk("pkt_byte", exp_q[i], g[7:0]);
      chk("pkt_last", i == len - 1, u_sink.lst[i]);
    end
    exp_q.delete();
  endtask
  // ==========================================================
  // clock, reset and watchdog
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = !i_clk;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    chk("watchdog", 0, 1);
    wrap_up();
  end
  // ==========================================================
  // tests
  initial begin
    {i_arst_n, i_read, i_write, i_event1, i_event2, slow} = 6'h00;
    i_address = 6'h00;
    i_writedata = 32'h0;
    i_init_flags = 4'hA;
    i_fix = 3'h0;
    repeat (12) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rd(R_IRQ_ST, q); chk("irq_st_rst", 0, q);
    rd(R_BUSY, q); chk("busy_rst", 0, q);
    rd(6'h3C, q); chk("unmapped", 0, q);
    for (int f = 0; f < 8; f++) begin
      i_fix <= 3'(f);
      wr(R_FLT, 32'hAA00);
      rd(R_FLT, q); chk("flt_word", {16'h0, 7'h55, 2'b0, 3'(f), 4'hA}, q);
    end
    i_event1 <= 1'b1;
    i_event2 <= 1'b1;
    rd(R_FLT, q); chk("flt_events", 32'hABFA, q);
    rd(R_IRQ_ST, q); chk("irq_events", 32'h06, q & 32'h17);
    i_event1 <= 1'b0;
    i_event2 <= 1'b0;
    wr(R_FLT, 32'hAB80);
    rd(R_FLT, q); chk("flt_clear", 32'hAA7A, q);
    wr(R_USEC, 32'hFFFFFFFF);
    rd(R_USEC, q); chk_rng("usec_clamp", 0, US_MAX, q);
    wr(R_SEC, 32'h12345678);
    wr(R_USEC, 32'h000F4236);
    repeat (1000) @(posedge i_clk);
    rd(R_SEC, q); chk("sec_wrap", 32'h12345679, q);
    rd(R_USEC, q); chk_rng("usec_wrap", 10, 40, q);
    slow <= 1'b1;
    rd(R_SEC, s);
    rd(R_USEC, u);
    push(s, 4);
    push(0, 4);
    pkt(PID_UNIX, 8, 4, u);
    slow <= 1'b0;
    wr(R_SYS, 32'hA5C3);
    push(32'hAA7A_A5C3, 4);
    pkt(PID_STAT, 4, -1, 0);
    wr(R_CAL0, 32'h016D07E8);
    wr(R_CAL1, 32'h17061F0B);
    wr(R_CAL2, 32'h3B3B);
    rd(R_USEC, u);
    push(0, 4);
    push(32'h016D07E8, 4);
    push(32'h17061F0B, 4);
    push(32'h3B3B, 2);
    pkt(PID_CAL, 14, 0, u);
    for (int i = 0; i < 13; i++) wr(R_DEV, 32'h3F800000 + 32'(i * 259));
    for (int k = 0; k < 4; k++) begin
      for (int i = 3 * k; i < 3 * k + 3 + (k == 3); i++) begin
        push(32'h3F800000 + 32'(i * 259), 4);
      end
      slow <= k[0];
      pkt(8'(PID_POSDEV + k), 12 + 4 * (k == 3), -1, 0);
    end
    wr(R_IRQ_EN, 32'h1F);
    @(negedge i_clk); chk("irq_on", 1, o_irq);
    rd(R_IRQ_ST, q); chk("irq_st", 32'h07, q & 32'h17);
    wr(R_IRQ_CLR, 32'h1F);
    rd(R_IRQ_ST, q); chk("irq_clr", 0, q & 32'h17);
    wr(R_IRQ_EN, 32'h10);
    @(negedge i_clk); chk("irq_off", 0, o_irq);
    wr(R_SEND, 32'h30);
    rd(R_IRQ_ST, q); chk("bad_id", 32'h10, q & 32'h17);
    @(negedge i_clk); chk("irq_bad", 1, o_irq);
    wr(R_IRQ_EN, 32'h0);
    @(negedge i_clk); chk("irq_mask", 0, o_irq);
    wr(R_IRQ_CLR, 32'h1F);
    slow <= 1'b1;
    u_sink.got.delete();
    wr(R_SEND, {24'h0, PID_QDEV});
    wr(R_SEND, {24'h0, PID_UNIX});
    rd(R_BUSY, q); chk("busy_on", 1, q & 32'h1);
    rd(R_IRQ_ST, q); chk("busy_refuse", 32'h10, q & 32'h17);
    repeat (100) @(posedge i_clk);
    chk("one_pkt", 16, u_sink.got.size());
    wrap_up();
  end
endmodule
